// [src/tpd_pkg.sv]
// package: register map, field layout and codes for the terminal drive and select block
package tpd_pkg;
   // ----------------------------------------
   // register indices (printed offsets) and byte addresses
   // ----------------------------------------
   localparam logic [7:0] TPD_IDX_FIRST_TRIGGER_TERMINAL = 8'h24;
   localparam logic [7:0] TPD_IDX_SECOND_TRIGGER_TERMINAL = 8'h25;
   localparam logic [7:0] TPD_IDX_MOD = 8'h26;
   localparam logic [7:0] TPD_IDX_OUT = 8'h27;
   localparam int TPD_ADDR_W = 12;
   localparam logic [11:0] TPD_ADDR_FIRST_TRIGGER_TERMINAL = {2'h0, TPD_IDX_FIRST_TRIGGER_TERMINAL, 2'h0};
   localparam logic [11:0] TPD_ADDR_SECOND_TRIGGER_TERMINAL = {2'h0, TPD_IDX_SECOND_TRIGGER_TERMINAL, 2'h0};
   localparam logic [11:0] TPD_ADDR_MOD = {2'h0, TPD_IDX_MOD, 2'h0};
   localparam logic [11:0] TPD_ADDR_OUT = {2'h0, TPD_IDX_OUT, 2'h0};
   localparam logic [11:0] TPD_ADDR_STATUS = 12'h0A0;
   // ----------------------------------------
   // field layout and reset values
   // ----------------------------------------
   localparam int TPD_DRV_LSB = 0;
   localparam int TPD_DRV_MSB = 2;
   localparam int TPD_SEL_LSB = 3;
   localparam int TPD_SEL_MSB = 7;
   localparam logic [7:0] TPD_CFG_RESET = 8'h00;
   localparam logic [1:0] TPD_RESP_OKAY = 2'h0;
   localparam logic [1:0] TPD_RESP_SLVERR = 2'h2;
   localparam int TPD_NUM_TERM = 4;
   // ----------------------------------------
   // drive-state codes
   // ----------------------------------------
   localparam logic [2:0] TPD_DRV_HIZ = 3'h0;
   localparam logic [2:0] TPD_DRV_OD = 3'h1;
   localparam logic [2:0] TPD_DRV_PP = 3'h2;
   localparam logic [2:0] TPD_DRV_RSVD = 3'h3;
   localparam logic [2:0] TPD_DRV_GND = 3'h4;
   localparam logic [2:0] TPD_DRV_OD_INV = 3'h5;
   localparam logic [2:0] TPD_DRV_PP_INV = 3'h6;
   localparam logic [2:0] TPD_DRV_INPUT = 3'h7;
   // ----------------------------------------
   // selector codes
   // ----------------------------------------
   localparam logic [4:0] TPD_SEL_GND = 5'h00;
   localparam logic [4:0] TPD_SEL_RAW_FIRST_TRIGGER_TERMINAL = 5'h01;
   localparam logic [4:0] TPD_SEL_RAW_SECOND_TRIGGER_TERMINAL = 5'h02;
   localparam logic [4:0] TPD_SEL_RAW_MOD = 5'h03;
   localparam logic [4:0] TPD_SEL_SYN_FIRST_TRIGGER_TERMINAL = 5'h04;
   localparam logic [4:0] TPD_SEL_SYN_SECOND_TRIGGER_TERMINAL = 5'h05;
   localparam logic [4:0] TPD_SEL_SYN_MOD = 5'h06;
   localparam logic [4:0] TPD_SEL_READBACK = 5'h07;
   localparam logic [4:0] TPD_SEL_COMPARATOR_ZERO_OUTPUT = 5'h08;
   localparam logic [4:0] TPD_SEL_COMPARATOR_ONE_OUTPUT = 5'h09;
   localparam logic [4:0] TPD_SEL_LOCK = 5'h0A;
   localparam logic [4:0] TPD_SEL_DLOCK = 5'h0B;
   localparam logic [4:0] TPD_SEL_CP_GOOD = 5'h0C;
   localparam logic [4:0] TPD_SEL_CP_HIGH = 5'h0D;
   localparam logic [4:0] TPD_SEL_CP_LOW = 5'h0E;
   // ----------------------------------------
   // bus slave states
   // ----------------------------------------
   typedef enum logic [1:0] {
      TPD_WR_IDLE = 2'b00,
      TPD_WR_RESP = 2'b01
   } tpd_wr_state_t;
endpackage : tpd_pkg

// [src/tpd_sync.sv]
// two-stage synchroniser for one terminal input
`timescale 1ns/100ps
module tpd_sync
   import tpd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic meta;
      logic sync;
   } tpd_sync_state_t;
   tpd_sync_state_t st_reg;
   tpd_sync_state_t st_next;

   // first stage is read only by the second stage
   always_comb begin
      st_next = st_reg;
      st_next.meta = din;
      st_next.sync = st_reg.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign dout = st_reg.sync;
endmodule : tpd_sync

// [src/tpd_term.sv]
// one terminal: signal select, drive-state decode, registered pin controls
`timescale 1ns/100ps
module tpd_term
   import tpd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] cfg,
   input wire logic [14:0] sources,
   output logic pin_o,
   output logic pin_oe_n,
   output logic sel_value
);
   typedef struct packed {
      logic pin_o;
      logic pin_oe_n;
      logic sel_value;
   } tpd_term_state_t;
   tpd_term_state_t st_reg;
   tpd_term_state_t st_next;
   logic [2:0] drv;
   logic [4:0] sel;
   logic s;

   assign drv = cfg[TPD_DRV_MSB:TPD_DRV_LSB];
   assign sel = cfg[TPD_SEL_MSB:TPD_SEL_LSB];

   always_comb begin
      st_next = st_reg;
      // codes above 14 belong to functions outside this block; they read as ground
      s = (sel <= TPD_SEL_CP_LOW) ? sources[sel[3:0]] : 1'b0;
      st_next.sel_value = s;
      st_next.pin_o = 1'b0;
      st_next.pin_oe_n = 1'b1;
      unique case (drv)
         TPD_DRV_HIZ, TPD_DRV_RSVD: begin
            st_next.pin_oe_n = 1'b1;
         end
         TPD_DRV_OD: begin
            st_next.pin_oe_n = s;
         end
         TPD_DRV_OD_INV: begin
            st_next.pin_oe_n = ~s;
         end
         TPD_DRV_PP: begin
            st_next.pin_o = s;
            st_next.pin_oe_n = 1'b0;
         end
         TPD_DRV_PP_INV: begin
            st_next.pin_o = ~s;
            st_next.pin_oe_n = 1'b0;
         end
         TPD_DRV_GND: begin
            st_next.pin_oe_n = 1'b0;
         end
         TPD_DRV_INPUT: begin
            st_next.pin_oe_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '{pin_o: 1'b0, pin_oe_n: 1'b1, sel_value: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign pin_o = st_reg.pin_o;
   assign pin_oe_n = st_reg.pin_oe_n;
   assign sel_value = st_reg.sel_value;
endmodule : tpd_term

// [src/tpd_top.sv]
// top: axi4-lite register file, input synchronisers and the four terminals
//
// Operation
// - each of four terminals has a 3-bit drive field, reset 0 = high impedance
// - code 1 open drain of selected signal, code 5 open drain of its inverse
// - code 2 drives actively with signal, code 6 drives inverted signal
// - selector 4 gives first trigger input after synchroniser
// - selector 5 gives second trigger input after synchroniser
// - selector 6 gives modulation input after synchroniser
// - selector 10 gives lock: digital lock and pump voltage within both thresholds
// - selector 13 gives pump voltage above high threshold
// - selector 14 gives pump voltage below low threshold
`timescale 1ns/100ps
module tpd_top
   import tpd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic first_trigger_terminal_i,
   output logic first_trigger_terminal_o,
   output logic first_trigger_terminal_oe_n,
   input wire logic second_trigger_terminal_i,
   output logic second_trigger_terminal_o,
   output logic second_trigger_terminal_oe_n,
   input wire logic modulation_terminal_i,
   output logic modulation_terminal_o,
   output logic modulation_terminal_oe_n,
   input wire logic multiplexed_output_terminal_i,
   output logic multiplexed_output_terminal_o,
   output logic multiplexed_output_terminal_oe_n,
   input wire logic readback_data,
   input wire logic comparator_zero_output,
   input wire logic comparator_one_output,
   input wire logic digital_lock_indication,
   input wire logic pump_voltage_high,
   input wire logic pump_voltage_low,
   output logic first_trigger_sync,
   output logic second_trigger_sync,
   output logic modulation_sync
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [TPD_NUM_TERM-1:0][7:0] cfg;
      logic aw_full;
      logic [11:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      tpd_wr_state_t wr_state;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [2:0] syn_out;
      // registered handshake outputs, so no bus port is driven through a gate
      logic awready;
      logic wready;
      logic bvalid;
      logic arready;
   } tpd_top_state_t;
   tpd_top_state_t st_reg;
   tpd_top_state_t st_next;

   logic syn_first_trigger_terminal;
   logic syn_second_trigger_terminal;
   logic syn_mod;
   logic combined_lock_indication;
   logic pump_in_range;
   logic [14:0] sources;
   logic [TPD_NUM_TERM-1:0] term_o;
   logic [TPD_NUM_TERM-1:0] term_oe_n;
   logic [TPD_NUM_TERM-1:0] term_val;

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   tpd_sync u_sync_first_trigger_terminal (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(first_trigger_terminal_i),
      .dout(syn_first_trigger_terminal)
   );
   tpd_sync u_sync_second_trigger_terminal (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(second_trigger_terminal_i),
      .dout(syn_second_trigger_terminal)
   );
   tpd_sync u_sync_mod (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(modulation_terminal_i),
      .dout(syn_mod)
   );

   // ----------------------------------------
   // selectable sources
   // ----------------------------------------
   assign pump_in_range = ~pump_voltage_high & ~pump_voltage_low;
   assign combined_lock_indication = digital_lock_indication & pump_in_range;

   // raw inputs are asynchronous to aclk; selecting them is a pass-through, not a clean sample
   always_comb begin
      sources = '0;
      sources[TPD_SEL_GND[3:0]] = 1'b0;
      sources[TPD_SEL_RAW_FIRST_TRIGGER_TERMINAL[3:0]] = first_trigger_terminal_i;
      sources[TPD_SEL_RAW_SECOND_TRIGGER_TERMINAL[3:0]] = second_trigger_terminal_i;
      sources[TPD_SEL_RAW_MOD[3:0]] = modulation_terminal_i;
      sources[TPD_SEL_SYN_FIRST_TRIGGER_TERMINAL[3:0]] = syn_first_trigger_terminal;
      sources[TPD_SEL_SYN_SECOND_TRIGGER_TERMINAL[3:0]] = syn_second_trigger_terminal;
      sources[TPD_SEL_SYN_MOD[3:0]] = syn_mod;
      sources[TPD_SEL_READBACK[3:0]] = readback_data;
      sources[TPD_SEL_COMPARATOR_ZERO_OUTPUT[3:0]] = comparator_zero_output;
      sources[TPD_SEL_COMPARATOR_ONE_OUTPUT[3:0]] = comparator_one_output;
      sources[TPD_SEL_LOCK[3:0]] = combined_lock_indication;
      sources[TPD_SEL_DLOCK[3:0]] = digital_lock_indication;
      sources[TPD_SEL_CP_GOOD[3:0]] = pump_in_range;
      sources[TPD_SEL_CP_HIGH[3:0]] = pump_voltage_high;
      sources[TPD_SEL_CP_LOW[3:0]] = pump_voltage_low;
   end

   // ----------------------------------------
   // terminals
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < TPD_NUM_TERM; gi++) begin : g_term
         tpd_term u_term (
            .aclk(aclk),
            .aresetn(aresetn),
            .cfg(st_reg.cfg[gi]),
            .sources(sources),
            .pin_o(term_o[gi]),
            .pin_oe_n(term_oe_n[gi]),
            .sel_value(term_val[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // status word
   // ----------------------------------------
   // read only; a write to it is answered okay and changes nothing
   logic [31:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[0] = pump_voltage_low;
      status_word[1] = pump_voltage_high;
      status_word[2] = pump_in_range;
      status_word[3] = combined_lock_indication;
      status_word[4] = first_trigger_terminal_i;
      status_word[5] = second_trigger_terminal_i;
      status_word[6] = modulation_terminal_i;
      status_word[7] = multiplexed_output_terminal_i;
      // selected values come from the terminal registers, one cycle behind their sources
      status_word[11:8] = term_val;
   end

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   function automatic logic [2:0] map_addr(input logic [11:0] a);
      logic [2:0] r;
      r = 3'h4;
      if (a == TPD_ADDR_FIRST_TRIGGER_TERMINAL) r = 3'h0;
      if (a == TPD_ADDR_SECOND_TRIGGER_TERMINAL) r = 3'h1;
      if (a == TPD_ADDR_MOD) r = 3'h2;
      if (a == TPD_ADDR_OUT) r = 3'h3;
      if (a == TPD_ADDR_STATUS) r = 3'h5;
      return r;
   endfunction : map_addr

   logic [2:0] wsel;
   logic [2:0] rsel;

   always_comb begin
      st_next = st_reg;
      wsel = map_addr(st_reg.aw_addr);
      rsel = map_addr(s_axi_araddr);
      st_next.syn_out = {syn_mod, syn_second_trigger_terminal, syn_first_trigger_terminal};
      // write channels taken independently, in either order
      if (s_axi_awvalid && !st_reg.aw_full) begin
         st_next.aw_full = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_reg.w_full) begin
         st_next.w_full = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      unique case (st_reg.wr_state)
         TPD_WR_IDLE: begin
            if (st_reg.aw_full && st_reg.w_full) begin
               st_next.bresp = TPD_RESP_OKAY;
               if (wsel < 3'h4) begin
                  // only byte lane 0 holds a field; other lanes are ignored
                  if (st_reg.w_strb[0]) begin
                     st_next.cfg[wsel[1:0]] = st_reg.w_data[7:0];
                  end
               end else if (wsel == 3'h4) begin
                  st_next.bresp = TPD_RESP_SLVERR;
               end
               st_next.wr_state = TPD_WR_RESP;
            end
         end
         TPD_WR_RESP: begin
            if (s_axi_bready) begin
               st_next.aw_full = 1'b0;
               st_next.w_full = 1'b0;
               st_next.wr_state = TPD_WR_IDLE;
            end
         end
         default: begin
            st_next.wr_state = TPD_WR_IDLE;
         end
      endcase
      // read: one at a time, answered the cycle after arvalid is taken
      if (st_reg.rvalid) begin
         if (s_axi_rready) begin
            st_next.rvalid = 1'b0;
         end
      end else if (s_axi_arvalid) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = TPD_RESP_OKAY;
         st_next.rdata = '0;
         if (rsel < 3'h4) begin
            st_next.rdata = {24'h000000, st_reg.cfg[rsel[1:0]]};
         end else if (rsel == 3'h5) begin
            st_next.rdata = status_word;
         end else begin
            st_next.rresp = TPD_RESP_SLVERR;
         end
      end
      // handshake outputs follow the next state, so they change on the same edge as before
      st_next.awready = ~st_next.aw_full;
      st_next.wready = ~st_next.w_full;
      st_next.bvalid = (st_next.wr_state == TPD_WR_RESP);
      st_next.arready = ~st_next.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
         st_reg.cfg <= {TPD_NUM_TERM{TPD_CFG_RESET}};
         st_reg.wr_state <= TPD_WR_IDLE;
         // ready outputs come up high so the first request after reset is taken at once
         st_reg.awready <= 1'b1;
         st_reg.wready <= 1'b1;
         st_reg.arready <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready = st_reg.wready;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign first_trigger_terminal_o = term_o[0];
   assign first_trigger_terminal_oe_n = term_oe_n[0];
   assign second_trigger_terminal_o = term_o[1];
   assign second_trigger_terminal_oe_n = term_oe_n[1];
   assign modulation_terminal_o = term_o[2];
   assign modulation_terminal_oe_n = term_oe_n[2];
   assign multiplexed_output_terminal_o = term_o[3];
   assign multiplexed_output_terminal_oe_n = term_oe_n[3];
   assign first_trigger_sync = st_reg.syn_out[0];
   assign second_trigger_sync = st_reg.syn_out[1];
   assign modulation_sync = st_reg.syn_out[2];
endmodule : tpd_top

// [tb/tpd_pin_model.sv]
// far-side model of one terminal: external driver plus a pull-up on the wire
`timescale 1ns/100ps
module tpd_pin_model (
   input wire logic dev_o,
   input wire logic dev_oe_n,
   input wire logic ext_val,
   input wire logic ext_en,
   output logic level
);
   // ----------------------------------------
   // wire resolution
   // ----------------------------------------
   // the device wins when it drives; a released wire takes ext_val when ext_en is set, else the pull-up, never its last value
   assign level = !dev_oe_n ? dev_o : (ext_en ? ext_val : 1'h1);
endmodule : tpd_pin_model

// [tb/tpd_top_assertions.sv]
// checker: bus handshake timing and pin behaviour of the terminal block
`timescale 1ns/100ps
module tpd_top_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic first_trigger_terminal_i,
   input wire logic second_trigger_terminal_i,
   input wire logic first_trigger_sync,
   input wire logic second_trigger_sync,
   input wire logic first_trigger_terminal_oe_n,
   input wire logic multiplexed_output_terminal_oe_n
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_wr_answer: assert property (wr_taken |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not on time");
   a_wr_busy: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
      else $error("write channels still ready");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write response not released");
   a_rd_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data not on time");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   // five quiet cycles cover the synchroniser depth with margin
   a_sync_first: assert property ((aresetn && $stable(first_trigger_terminal_i))[*5] |->
      first_trigger_sync == first_trigger_terminal_i) else $error("first sync wrong");
   a_sync_second: assert property ((aresetn && $stable(second_trigger_terminal_i))[*5] |->
      second_trigger_sync == second_trigger_terminal_i) else $error("second sync wrong");
   a_reset_hiz: assert property ($rose(aresetn) |-> first_trigger_terminal_oe_n && multiplexed_output_terminal_oe_n)
      else $error("terminal driven after reset");
endmodule : tpd_top_assertions
bind tpd_top tpd_top_assertions chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .first_trigger_terminal_i(first_trigger_terminal_i),
   .second_trigger_terminal_i(second_trigger_terminal_i), .first_trigger_sync(first_trigger_sync),
   .second_trigger_sync(second_trigger_sync), .first_trigger_terminal_oe_n(first_trigger_terminal_oe_n),
   .multiplexed_output_terminal_oe_n(multiplexed_output_terminal_oe_n));

// [tb/tb_top.sv]
// testbench: register access, drive codes and selector table of the terminal block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import tpd_pkg::*;
   // ----------------------------------------
   // stimulus signals
   // ----------------------------------------
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] pin_o, pin_oe_n, lvl, ext_val = 4'h0, ext_en = 4'h7;
   logic rb = 1'h0, c0 = 1'h0, c1 = 1'h0, dl = 1'h0, hi = 1'h0, lo = 1'h0;
   logic [2:0] syn;
   logic [8:0] pats [3] = '{9'h055, 9'h0AA, 9'h155};
   int errors = 0, samples_checked = 0;
   always #25 aclk = ~aclk;
   tpd_pin_model pm_u[3:0] (.dev_o(pin_o), .dev_oe_n(pin_oe_n), .ext_val(ext_val), .ext_en(ext_en), .level(lvl));
   tpd_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .first_trigger_terminal_i(lvl[0]), .first_trigger_terminal_o(pin_o[0]), .first_trigger_terminal_oe_n(pin_oe_n[0]),
      .second_trigger_terminal_i(lvl[1]), .second_trigger_terminal_o(pin_o[1]), .second_trigger_terminal_oe_n(pin_oe_n[1]),
      .modulation_terminal_i(lvl[2]), .modulation_terminal_o(pin_o[2]), .modulation_terminal_oe_n(pin_oe_n[2]),
      .multiplexed_output_terminal_i(lvl[3]), .multiplexed_output_terminal_o(pin_o[3]),
      .multiplexed_output_terminal_oe_n(pin_oe_n[3]), .readback_data(rb), .comparator_zero_output(c0),
      .comparator_one_output(c1), .digital_lock_indication(dl), .pump_voltage_high(hi), .pump_voltage_low(lo),
      .first_trigger_sync(syn[0]), .second_trigger_sync(syn[1]), .modulation_sync(syn[2]));
   // ----------------------------------------
   // bus tasks and expectations
   // ----------------------------------------
   // bready and rready go up with the request and stay up, so an answer is taken at its first edge
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic done;
      done = 1'h0;
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid && bready) begin r = bresp; done = 1'h1; end
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'h0;
      araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid && rready) begin d = rdata; r = rresp; done = 1'h1; end
      end
   endtask : axi_rd
   function automatic logic exp_oe_n(input logic [2:0] code, input logic s);
      case (code)
         TPD_DRV_OD: exp_oe_n = s;
         TPD_DRV_OD_INV: exp_oe_n = ~s;
         TPD_DRV_PP, TPD_DRV_PP_INV, TPD_DRV_GND: exp_oe_n = 1'h0;
         default: exp_oe_n = 1'h1;
      endcase
   endfunction : exp_oe_n
   function automatic logic exp_lvl(input logic [2:0] code, input logic s);
      case (code)
         TPD_DRV_OD, TPD_DRV_PP: exp_lvl = s;
         TPD_DRV_OD_INV, TPD_DRV_PP_INV: exp_lvl = ~s;
         TPD_DRV_GND: exp_lvl = 1'h0;
         default: exp_lvl = 1'h1;
      endcase
   endfunction : exp_lvl
   function automatic logic exp_sel(input logic [4:0] sel, input logic [8:0] p);
      logic [14:0] v;
      v = {p[8], p[7], ~p[7] & ~p[8], p[6], p[6] & ~p[7] & ~p[8], p[5:3], p[2:0], p[2:0], 1'h0};
      exp_sel = v[sel];
   endfunction : exp_sel
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (5000) @(posedge aclk);
      errors++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      `CHK("oe_n after reset", 4'hF, pin_oe_n)
      `CHK("o after reset", 4'h0, pin_o)
      for (int i = 0; i < 4; i++) begin
         axi_rd(12'(TPD_ADDR_FIRST_TRIGGER_TERMINAL + 4 * i), rd, resp);
         `CHK("cfg after reset", {24'h0, TPD_CFG_RESET}, rd)
      end
      axi_wr(TPD_ADDR_MOD, 32'hFFFFFF13, 4'hF, resp);
      `CHK("write resp", TPD_RESP_OKAY, resp)
      axi_wr(TPD_ADDR_MOD, 32'h00000000, 4'h0, resp);
      axi_rd(TPD_ADDR_MOD, rd, resp);
      `CHK("mod cfg", 32'h00000013, rd)
      `CHK("reserved code oe_n", 1'h1, pin_oe_n[2])
      axi_rd(12'h000, rd, resp);
      `CHK("unmapped read resp", TPD_RESP_SLVERR, resp)
      `CHK("unmapped read data", 32'h00000000, rd)
      axi_wr(12'h004, 32'h000000FF, 4'hF, resp);
      `CHK("unmapped write resp", TPD_RESP_SLVERR, resp)
      for (int c = 0; c < 8; c++) begin
         for (int s = 0; s < 2; s++) begin
            c0 <= s[0];
            axi_wr(TPD_ADDR_OUT, {24'h0, TPD_SEL_COMPARATOR_ZERO_OUTPUT, c[2:0]}, 4'hF, resp);
            repeat (3) @(posedge aclk);
            `CHK("out oe_n", exp_oe_n(c[2:0], s[0]), pin_oe_n[3])
            `CHK("out level", exp_lvl(c[2:0], s[0]), lvl[3])
         end
      end
      for (int k = 0; k < 3; k++) begin
         ext_val[2:0] <= pats[k][2:0];
         {lo, hi, dl, c1, c0, rb} <= pats[k][8:3];
         for (int s = 0; s < 15; s++) begin
            axi_wr(TPD_ADDR_OUT, {24'h0, 5'(s), TPD_DRV_PP}, 4'hF, resp);
            repeat (6) @(posedge aclk);
            `CHK("selected", exp_sel(5'(s), pats[k]), lvl[3])
         end
         `CHK("sync outputs", pats[k][2:0], syn)
      end
      axi_wr(TPD_ADDR_STATUS, 32'h00000FFF, 4'hF, resp);
      `CHK("status write resp", TPD_RESP_OKAY, resp)
      axi_rd(TPD_ADDR_STATUS, rd, resp);
      `CHK("status word", 32'h000008D1, rd)
      report_and_stop();
   end
endmodule : tb_top
